/* File: pcd_engine.sv */
// Page chained descriptor DMA engine with register port and sequencer
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pcd_engine import pcd_pkg::*; (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic to_card,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic card_tx_valid,
	output logic [31:0] card_tx_data,
	input wire logic card_tx_ready,
	input wire logic card_rx_valid,
	input wire logic [31:0] card_rx_data,
	output logic card_rx_ready,
	output logic card_read_suspend,
	output logic dma_irq,
	output logic desc_fault_irq,
	output logic gap_halt_irq,
	output logic xfer_done
);
	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	pcd_state_type state_q;
	logic [63:0] descriptor_pointer_reg_q;
	logic [31:0] xfer_addr_reg_q, xfer_len_reg_q, line_q, rdata_q;
	logic [1:0] dma_mode_field_q;
	logic halt_between_blocks_req_q;
	logic st_done_q, st_fault_q, st_gap_q, st_line_q, suspend_q;
	logic fetch_pend_q, mv_start_q;
	logic mv_busy, mv_done, mv_req, mv_we;
	logic [31:0] mv_addr, mv_wdata;

	function automatic logic [31:0] page_field(input logic [31:0] line);
		page_field = {line[31:PCD_FLD_LSB], 12'h000};
	endfunction

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	wire logic wr_ptr_lo = reg_wr && reg_addr == PCD_OFS_PTR_LO;
	wire logic wr_ptr_hi = reg_wr && reg_addr == PCD_OFS_PTR_HI;
	wire logic wr_ctrl = reg_wr && reg_addr == PCD_OFS_CTRL;
	wire logic wr_cmd = reg_wr && reg_addr == PCD_OFS_CMD;
	wire logic wr_stat = reg_wr && reg_addr == PCD_OFS_STATUS;
	wire logic idle = state_q == pcd_halted_state;
	// Starts only in the page mode; other modes belong to other engines
	wire logic start = wr_cmd && idle && dma_mode_field_q == PCD_MODE_V1;
	wire logic [31:0] caps_word = 32'h1 << PCD_CAP_BIT;
	wire logic [31:0] ctrl_word = {23'h0, halt_between_blocks_req_q, 3'h0,
		dma_mode_field_q, 3'h0};
	wire logic [31:0] stat_word = {26'h0, suspend_q, !idle, st_line_q, st_gap_q,
		st_fault_q, st_done_q};
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			PCD_OFS_PTR_LO: rd_mux = descriptor_pointer_reg_q[31:0];
			PCD_OFS_PTR_HI: rd_mux = descriptor_pointer_reg_q[63:32];
			PCD_OFS_CTRL: rd_mux = ctrl_word;
			PCD_OFS_STATUS: rd_mux = stat_word;
			PCD_OFS_CAPS: rd_mux = caps_word;
			PCD_OFS_ADDR: rd_mux = xfer_addr_reg_q;
			PCD_OFS_LEN: rd_mux = xfer_len_reg_q;
			default: rd_mux = 32'h0;
		endcase
	end
	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// Descriptor line fields
	// ----------------------------------------
	wire logic [1:0] line_op = {line_q[PCD_BIT_ACT_HI], line_q[PCD_BIT_ACT_LO]};
	wire logic line_valid = line_q[PCD_BIT_VALID];
	wire logic line_last = line_q[PCD_BIT_LAST];
	wire logic line_irq = line_q[PCD_BIT_IRQ];
	// Only the low word of the pointer drives the memory address
	wire logic [31:0] fetch_addr = descriptor_pointer_reg_q[31:0];
	wire logic fetch_ack = fetch_pend_q && mem_ack;
	wire logic line_end = (state_q == pcd_transfer_state) &&
		(line_op != PCD_OP_MOVE || mv_done);
	wire logic gap_hit = line_end && halt_between_blocks_req_q && line_op == PCD_OP_MOVE;

	// Memory port shared between fetch and mover; never both at once
	assign mem_req = fetch_pend_q || mv_req;
	assign mem_we = fetch_pend_q ? 1'b0 : mv_we;
	assign mem_addr = fetch_pend_q ? fetch_addr : mv_addr;
	assign mem_wdata = mv_wdata;
	assign dma_irq = st_line_q;
	assign desc_fault_irq = st_fault_q;
	assign gap_halt_irq = st_gap_q;
	assign xfer_done = st_done_q;
	assign card_read_suspend = suspend_q;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= pcd_halted_state;
			fetch_pend_q <= 1'b0;
			line_q <= 32'h0;
			mv_start_q <= 1'b0;
		end else begin
			mv_start_q <= 1'b0;
			case (state_q)
				pcd_halted_state: begin
					if (start) state_q <= pcd_fetch_req;
				end
				pcd_fetch_req: begin
					fetch_pend_q <= 1'b1;
					state_q <= pcd_fetch_state;
				end
				pcd_fetch_state: begin
					if (fetch_ack) begin
						fetch_pend_q <= 1'b0;
						line_q <= mem_rdata;
						state_q <= pcd_address_change_state;
					end
				end
				pcd_address_change_state: begin
					// No error check here; faults are taken in the transfer state
					state_q <= pcd_transfer_state;
					if (line_valid && line_op == PCD_OP_MOVE && !halt_between_blocks_req_q)
						mv_start_q <= 1'b1;
				end
				pcd_transfer_state: begin
					if (!line_valid) state_q <= pcd_halted_state;
					else if (line_op == PCD_OP_MOVE && !mv_busy && !mv_start_q && !mv_done
						&& halt_between_blocks_req_q) state_q <= pcd_transfer_state;
					else if (line_end) begin
						if (line_last) state_q <= pcd_halted_state;
						else state_q <= pcd_fetch_req;
					end else if (line_op == PCD_OP_MOVE && !mv_busy && !mv_start_q)
						mv_start_q <= 1'b1;
				end
				default: state_q <= pcd_halted_state;
			endcase
		end
	end

	// ----------------------------------------
	// Address, length and control registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			descriptor_pointer_reg_q <= 64'h0;
			xfer_addr_reg_q <= 32'h0;
			xfer_len_reg_q <= PCD_PAGE_BYTES;
			dma_mode_field_q <= 2'h0;
			halt_between_blocks_req_q <= 1'b0;
		end else begin
			if (wr_ptr_lo && idle) descriptor_pointer_reg_q[31:0] <= reg_wdata;
			if (wr_ptr_hi && idle) descriptor_pointer_reg_q[63:32] <= reg_wdata;
			if (wr_ctrl) begin
				dma_mode_field_q <= reg_wdata[PCD_MODE_LSB +: 2];
				halt_between_blocks_req_q <= reg_wdata[PCD_CTRL_GAP];
			end
			if (start) xfer_len_reg_q <= PCD_PAGE_BYTES;
			if (state_q == pcd_address_change_state && line_valid) begin
				if (line_op == PCD_OP_CHAIN)
					descriptor_pointer_reg_q[31:0] <= page_field(line_q);
				else
					descriptor_pointer_reg_q[31:0] <= fetch_addr + PCD_LINE_BYTES;
				if (line_op == PCD_OP_LEN)
					xfer_len_reg_q <= {4'h0, line_q[27:PCD_FLD_LSB], 12'h000};
				if (line_op == PCD_OP_MOVE) xfer_addr_reg_q <= page_field(line_q);
			end
		end
	end

	// ----------------------------------------
	// Status flags; a set beats a same-cycle clear
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_done_q <= 1'b0;
			st_fault_q <= 1'b0;
			st_gap_q <= 1'b0;
			st_line_q <= 1'b0;
			suspend_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 32'h0;
			if (wr_stat && reg_wdata[PCD_ST_DONE]) st_done_q <= 1'b0;
			if (wr_stat && reg_wdata[PCD_ST_FAULT]) st_fault_q <= 1'b0;
			if (wr_stat && reg_wdata[PCD_ST_GAP]) st_gap_q <= 1'b0;
			if (wr_stat && reg_wdata[PCD_ST_LINEIRQ]) st_line_q <= 1'b0;
			if (state_q == pcd_transfer_state && !line_valid) st_fault_q <= 1'b1;
			if (line_end && line_valid && line_last) st_done_q <= 1'b1;
			if (line_end && line_valid && line_irq) st_line_q <= 1'b1;
			if (gap_hit) st_gap_q <= 1'b1;
			// Card reads pause once the page ends and resume when the request drops
			if (gap_hit && !to_card) suspend_q <= 1'b1;
			else if (!halt_between_blocks_req_q) suspend_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Page mover
	// ----------------------------------------
	pcd_word_mover u_mover (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.start(mv_start_q),
		.base_addr(xfer_addr_reg_q),
		.byte_len(xfer_len_reg_q),
		.to_card(to_card),
		.hold(fetch_pend_q),
		.busy(mv_busy),
		.done(mv_done),
		.mem_req(mv_req),
		.mem_we(mv_we),
		.mem_addr(mv_addr),
		.mem_wdata(mv_wdata),
		.mem_ack(mv_req && mem_ack),
		.mem_rdata(mem_rdata),
		.card_tx_valid(card_tx_valid),
		.card_tx_data(card_tx_data),
		.card_tx_ready(card_tx_ready),
		.card_rx_valid(card_rx_valid),
		.card_rx_data(card_rx_data),
		.card_rx_ready(card_rx_ready)
	);
endmodule
`default_nettype wire

/* File: pcd_pkg.sv */
// Package of constants and types for the page chained descriptor engine
//
// Overview of operation
// - Descriptor line: 20-bit address/length in 31:12, reserved zeros, attributes low.
// - Line with effective bit clear raises fault interrupt and halts engine.
// - Skip line, both action bits clear, does nothing and moves on.
// - Load-length line copies 31:12 into length register; 31:28 must be zero.
// - Every start presets the length register to one 4KB page.
// - Move line loads transfer address register, then moves that page.
// - Chain line loads descriptor pointer, next fetches come from there.
// - Sequencer rests halted after reset and after all transfers finish.
// - Command register write leaves halted state and enters fetch; here only while the mode field is 01.
// - Fetch reads one line, latches its fields, then goes to address change.
// - Address change steps pointer by one line, except chain loads new table.
// - Address change never halts on errors; it goes to transfer whatever the last flag.
// - Transfer moves one line's data; last clear returns to fetch, else halt.
// - Halt-between-blocks request raises gap interrupt once current page finishes.
// - Card read halted at a gap is suspended by read wait or clock stop.
// - Mode field bits 4:3: 00 none/single, 01 this engine, 10/11 version two.
// - Capability bit 20 reads one because this engine is implemented.
// - Low 12 bits of every descriptor address are taken as zero.
// - Pointer register is 64 bits, only its low 32 bits address memory.
package pcd_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] PCD_OFS_PTR_LO = 8'h00;
	localparam logic [7:0] PCD_OFS_PTR_HI = 8'h04;
	localparam logic [7:0] PCD_OFS_CTRL = 8'h08;
	localparam logic [7:0] PCD_OFS_CMD = 8'h0c;
	localparam logic [7:0] PCD_OFS_STATUS = 8'h10;
	localparam logic [7:0] PCD_OFS_CAPS = 8'h14;
	localparam logic [7:0] PCD_OFS_ADDR = 8'h18;
	localparam logic [7:0] PCD_OFS_LEN = 8'h1c;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PCD_BIT_VALID = 0;
	localparam int PCD_BIT_LAST = 1;
	localparam int PCD_BIT_IRQ = 2;
	localparam int PCD_BIT_ACT_LO = 4;
	localparam int PCD_BIT_ACT_HI = 5;
	localparam int PCD_FLD_LSB = 12;
	localparam int PCD_MODE_LSB = 3;
	localparam int PCD_CTRL_GAP = 8;
	localparam int PCD_CAP_BIT = 20;
	localparam int PCD_ST_DONE = 0;
	localparam int PCD_ST_FAULT = 1;
	localparam int PCD_ST_GAP = 2;
	localparam int PCD_ST_LINEIRQ = 3;
	localparam int PCD_ST_BUSY = 4;
	localparam int PCD_ST_SUSP = 5;
	// ----------------------------------------
	// Values
	// ----------------------------------------
	localparam logic [1:0] PCD_MODE_V1 = 2'h1;
	localparam logic [31:0] PCD_PAGE_BYTES = 32'h0000_1000;
	localparam logic [1:0] PCD_OP_SKIP = 2'h0;
	localparam logic [1:0] PCD_OP_LEN = 2'h1;
	localparam logic [1:0] PCD_OP_MOVE = 2'h2;
	localparam logic [1:0] PCD_OP_CHAIN = 2'h3;
	localparam logic [31:0] PCD_LINE_BYTES = 32'h0000_0004;
	localparam logic [31:0] PCD_WORD_BYTES = 32'h0000_0004;
	typedef enum logic [2:0] {
		pcd_halted_state,
		pcd_fetch_req,
		pcd_fetch_state,
		pcd_address_change_state,
		pcd_transfer_state
	} pcd_state_type;
endpackage

/* File: pcd_word_mover.sv */
// Word mover that streams byte_len bytes between memory and the card data path
`timescale 1ns/1ps
`default_nettype none
module pcd_word_mover import pcd_pkg::*; (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [31:0] base_addr,
	input wire logic [31:0] byte_len,
	input wire logic to_card,
	input wire logic hold,
	output logic busy,
	output logic done,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic card_tx_valid,
	output logic [31:0] card_tx_data,
	input wire logic card_tx_ready,
	input wire logic card_rx_valid,
	input wire logic [31:0] card_rx_data,
	output logic card_rx_ready
);
	logic busy_q, done_q, dir_q, have_q, pend_q;
	logic [31:0] addr_q, left_q, data_q;
	wire logic need = busy_q && left_q != 32'h0;
	wire logic mem_fire = pend_q && mem_ack;
	wire logic rx_fire = card_rx_valid && card_rx_ready;
	wire logic tx_fire = card_tx_valid && card_tx_ready;
	wire logic step = mem_fire && (dir_q || !have_q);
	wire logic [31:0] left_dec = (left_q > PCD_WORD_BYTES) ? left_q - PCD_WORD_BYTES : 32'h0;
	assign busy = busy_q;
	assign done = done_q;
	assign mem_req = pend_q;
	assign mem_we = !dir_q;
	assign mem_addr = addr_q;
	assign mem_wdata = data_q;
	// Pauses at word edges only, so a hold never tears a word
	assign card_rx_ready = need && !dir_q && !have_q && !pend_q && !hold;
	assign card_tx_valid = busy_q && dir_q && have_q;
	assign card_tx_data = data_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			dir_q <= 1'b0;
			have_q <= 1'b0;
			pend_q <= 1'b0;
			addr_q <= 32'h0;
			left_q <= 32'h0;
			data_q <= 32'h0;
		end else begin
			done_q <= 1'b0;
			if (start && !busy_q) begin
				busy_q <= 1'b1;
				dir_q <= to_card;
				addr_q <= base_addr;
				left_q <= byte_len;
				have_q <= 1'b0;
			end else if (busy_q) begin
				if (dir_q && !have_q && !pend_q && left_q != 32'h0 && !hold) pend_q <= 1'b1;
				if (rx_fire) begin
					data_q <= card_rx_data;
					have_q <= 1'b1;
					pend_q <= 1'b1;
				end
				if (mem_fire) begin
					pend_q <= 1'b0;
					addr_q <= addr_q + PCD_WORD_BYTES;
					left_q <= left_dec;
					if (dir_q) begin
						data_q <= mem_rdata;
						have_q <= 1'b1;
					end else have_q <= 1'b0;
				end
				if (tx_fire) have_q <= 1'b0;
				if (left_q == 32'h0 && !have_q && !pend_q && !step) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: pcd_engine_assertions.sv */
// Concurrent checks on the ports of the page chained descriptor engine
`timescale 1ns/1ps
`default_nettype none
module pcd_engine_chk import pcd_pkg::*; (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic to_card,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic card_tx_valid,
	input wire logic [31:0] card_tx_data,
	input wire logic card_tx_ready,
	input wire logic card_read_suspend,
	input wire logic desc_fault_irq,
	input wire logic gap_halt_irq,
	input wire logic xfer_done
);
	// Shadow of software state; pointer writes only count while idle
	logic [1:0] mode_q;
	logic gap_q;
	logic run_q;
	logic [31:0] ptr_q;
	wire logic ctrl_wr = reg_wr && reg_addr == PCD_OFS_CTRL;
	wire logic ptr_wr = reg_wr && reg_addr == PCD_OFS_PTR_LO && !run_q;
	wire logic start = reg_wr && reg_addr == PCD_OFS_CMD && mode_q == PCD_MODE_V1 && !run_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_q <= 2'h0;
			gap_q <= 1'b0;
			run_q <= 1'b0;
			ptr_q <= 32'h0;
		end else begin
			if (ctrl_wr) begin
				mode_q <= reg_wdata[PCD_MODE_LSB +: 2];
				gap_q <= reg_wdata[PCD_CTRL_GAP];
			end
			if (ptr_wr) begin
				ptr_q <= reg_wdata;
			end
			run_q <= start | (run_q & ~xfer_done & ~desc_fault_irq);
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_fetch;
		mem_req && !mem_we && mem_addr == ptr_q;
	endsequence
	a_start_fetch: assert property (start |-> ##2 s_fetch)
		else $error("no fetch after start");
	a_caps_bit: assert property (reg_rd && reg_addr == PCD_OFS_CAPS |=> reg_rdata[PCD_CAP_BIT])
		else $error("capability bit low");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("request dropped");
	a_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
		else $error("unaligned address");
	a_fault_halt: assert property (desc_fault_irq |-> !mem_req)
		else $error("busy after fault");
	a_done_quiet: assert property ($rose(xfer_done) |-> !mem_req [*3])
		else $error("busy after done");
	a_gap_cause: assert property ($rose(gap_halt_irq) |-> gap_q)
		else $error("gap irq without request");
	a_suspend_dir: assert property ($rose(card_read_suspend) |-> !to_card)
		else $error("suspend on card write");
	a_tx_hold: assert property (card_tx_valid && !card_tx_ready |=> $stable(card_tx_data))
		else $error("card data changed");
endmodule
bind pcd_engine pcd_engine_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .to_card(to_card), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr), .mem_ack(mem_ack), .card_tx_valid(card_tx_valid),
	.card_tx_data(card_tx_data), .card_tx_ready(card_tx_ready),
	.card_read_suspend(card_read_suspend), .desc_fault_irq(desc_fault_irq),
	.gap_halt_irq(gap_halt_irq), .xfer_done(xfer_done));
`default_nettype wire

/* File: pcd_mem_model.sv */
// System memory model answering word requests after a set latency
`timescale 1ns/1ps
`default_nettype none
module pcd_mem_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [1:0] lat,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [logic [31:0]];
	logic [1:0] wait_q;
	assign mem_ack = mem_req && wait_q == lat;
	// Unwritten words read as their address; no stale data outside an answer
	always_comb begin
		mem_rdata = ~mem_addr;
		if (mem_ack) begin
			mem_rdata = mem.exists(mem_addr) ? mem[mem_addr] : mem_addr;
		end
	end
	always_ff @(posedge clk_sys) begin
		wait_q <= (sys_rst || !mem_req || mem_ack) ? 2'h0 : wait_q + 2'h1;
	end
	always @(posedge clk_sys) begin
		if (mem_ack && mem_we) begin
			mem[mem_addr] = mem_wdata;
		end
	end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the page chained descriptor engine
`timescale 1ns/1ps
`default_nettype none
module tb import pcd_pkg::*; ();
	logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, to_card = 1'b1;
	logic card_tx_ready = 1'b0, card_rx_valid = 1'b1;
	logic [1:0] lat = 2'h3;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, card_rx_data = 32'h0, tx_count = 32'h0, rx_count = 32'h0;
	logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, card_tx_data, first_tx, rd_val;
	logic mem_req, mem_we, mem_ack, card_tx_valid, card_rx_ready, card_read_suspend;
	logic dma_irq, desc_fault_irq, gap_halt_irq, xfer_done;
	int fail_count = 0, compares = 0;
	always #10 clk_sys = ~clk_sys;
	pcd_engine dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.to_card(to_card), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.card_tx_valid(card_tx_valid), .card_tx_data(card_tx_data),
		.card_tx_ready(card_tx_ready), .card_rx_valid(card_rx_valid),
		.card_rx_data(card_rx_data), .card_rx_ready(card_rx_ready),
		.card_read_suspend(card_read_suspend), .dma_irq(dma_irq),
		.desc_fault_irq(desc_fault_irq), .gap_halt_irq(gap_halt_irq), .xfer_done(xfer_done));
	pcd_mem_model u_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .lat(lat), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));
	// Card write side stalls every other cycle; read data is a running count, always valid
	always @(posedge clk_sys) begin
		card_tx_ready <= ~card_tx_ready;
		if (card_tx_valid && card_tx_ready) begin
			first_tx <= (tx_count == 32'h0) ? card_tx_data : first_tx;
			tx_count <= tx_count + 32'h1;
		end
		if (card_rx_valid && card_rx_ready) begin
			card_rx_data <= card_rx_data + 32'h1;
			rx_count <= rx_count + 32'h1;
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_val, exp);
	endtask
	// Bounded wait for gap, fault or done
	task automatic wait_evt(input logic [2:0] m);
		int n = 0;
		while (({gap_halt_irq, desc_fault_irq, xfer_done} & m) === 3'h0 && n < 20000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk({31'h0, n < 20000}, 32'h1);
	endtask
	task automatic give_verdict;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		give_verdict;
	end
	initial begin
		// Tables keep reserved bits zero
		u_mem.mem[32'h1000] = 32'h0000_0005;
		u_mem.mem[32'h1004] = 32'h0000_2011;
		u_mem.mem[32'h1008] = 32'h0000_3031;
		u_mem.mem[32'h3000] = 32'h0000_3013;
		u_mem.mem[32'h2000] = 32'h0000_5023;
		u_mem.mem[32'h6000] = 32'h0000_0020;
		u_mem.mem[32'h4000] = 32'h0000_7021;
		u_mem.mem[32'h4004] = 32'h0000_0003;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk_reg(PCD_OFS_CAPS, 32'h0010_0000);
		chk_reg(PCD_OFS_LEN, PCD_PAGE_BYTES);
		chk_reg(PCD_OFS_STATUS, 32'h0);
		chk_reg(8'h40, 32'h0);
		wr(PCD_OFS_CTRL, 32'h0000_0010);
		wr(PCD_OFS_CMD, 32'h1);
		chk_reg(PCD_OFS_STATUS, 32'h0);
		chk_reg(PCD_OFS_CTRL, 32'h0000_0010);
		$display("test reset and mode ended");
		wr(PCD_OFS_CTRL, 32'h0000_0008);
		wr(PCD_OFS_PTR_LO, 32'h0000_1000);
		wr(PCD_OFS_PTR_HI, 32'h0000_00ab);
		wr(PCD_OFS_CMD, 32'h1);
		wait_evt(3'h1);
		chk({31'h0, dma_irq}, 32'h1);
		chk_reg(PCD_OFS_LEN, 32'h0000_3000);
		chk_reg(PCD_OFS_PTR_LO, 32'h0000_3004);
		chk_reg(PCD_OFS_PTR_HI, 32'h0000_00ab);
		chk_reg(PCD_OFS_STATUS, 32'h0000_0009);
		wr(PCD_OFS_STATUS, 32'h0000_000f);
		$display("test walk and chain ended");
		lat <= 2'h0;
		wr(PCD_OFS_PTR_LO, 32'h0000_2000);
		wr(PCD_OFS_CMD, 32'h1);
		wait_evt(3'h1);
		chk_reg(PCD_OFS_LEN, PCD_PAGE_BYTES);
		chk_reg(PCD_OFS_ADDR, 32'h0000_5000);
		chk(tx_count, 32'h0000_0400);
		chk(first_tx, 32'h0000_5000);
		wr(PCD_OFS_STATUS, 32'h0000_000f);
		$display("test page to card ended");
		wr(PCD_OFS_PTR_LO, 32'h0000_6000);
		wr(PCD_OFS_CMD, 32'h1);
		wait_evt(3'h2);
		chk_reg(PCD_OFS_STATUS, 32'h0000_0002);
		wr(PCD_OFS_STATUS, 32'h0000_000f);
		$display("test invalid line ended");
		to_card <= 1'b0;
		wr(PCD_OFS_PTR_LO, 32'h0000_4000);
		wr(PCD_OFS_CMD, 32'h1);
		repeat (40) @(posedge clk_sys);
		wr(PCD_OFS_CTRL, 32'h0000_0108);
		wait_evt(3'h4);
		chk(rx_count, 32'h0000_0400);
		chk({31'h0, card_read_suspend}, 32'h1);
		wr(PCD_OFS_CTRL, 32'h0000_0008);
		wait_evt(3'h1);
		chk_reg(PCD_OFS_STATUS, 32'h0000_0005);
		chk(u_mem.mem[32'h7000], 32'h0);
		chk(u_mem.mem[32'h7ffc], 32'h0000_03ff);
		$display("test block gap ended");
		// Reset lands mid-page; flags and pointer must all return to rest
		wr(PCD_OFS_PTR_LO, 32'h0000_4000);
		wr(PCD_OFS_CMD, 32'h1);
		repeat (20) @(posedge clk_sys);
		chk_reg(PCD_OFS_STATUS, 32'h0000_0015);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk_reg(PCD_OFS_STATUS, 32'h0);
		chk_reg(PCD_OFS_PTR_LO, 32'h0);
		chk_reg(PCD_OFS_PTR_HI, 32'h0);
		$display("test reset mid run ended");
		give_verdict;
	end
endmodule
`default_nettype wire
